// File: src/ulsb_regs.vh
// register offsets, field positions, reset values and timing counts of the serial port status block
`ifndef ULSB_REGS_VH
`define ULSB_REGS_VH
// register byte offsets
`define ULSB_A_BUF      6'h00
`define ULSB_A_IER      6'h04
`define ULSB_A_FCTL     6'h08
`define ULSB_A_LCR      6'h0c
`define ULSB_A_LSR      6'h14
`define ULSB_A_DLL      6'h20
`define ULSB_A_DLH      6'h24
`define ULSB_A_PWR      6'h30
`define ULSB_A_MDR      6'h34
// line status fields
`define ULSB_LS_DR      0
`define ULSB_LS_OE      1
`define ULSB_LS_PE      2
`define ULSB_LS_FE      3
`define ULSB_LS_BI      4
`define ULSB_LS_TX_HOLD_EMPTY    5
`define ULSB_LS_TX_ALL_EMPTY    6
`define ULSB_LS_RX_FIFO_ERROR    7
// line format fields
`define ULSB_LCR_DIVISOR_SELECT   7
`define ULSB_LCR_BC     6
`define ULSB_LCR_SP     5
`define ULSB_LCR_EPS    4
`define ULSB_LCR_PEN    3
`define ULSB_LCR_STB    2
// interrupt enable fields
`define ULSB_IE_RX      0
`define ULSB_IE_TX      1
`define ULSB_IE_LS      2
// power/emulation fields
`define ULSB_PW_FREE    0
`define ULSB_PW_RXRUN   13
`define ULSB_PW_TXRUN   14
// fifo control fields
`define ULSB_FC_EN      0
`define ULSB_FC_RXCLR   1
`define ULSB_FC_TXCLR   2
// reset values
`define ULSB_LCR_RST    8'h00
`define ULSB_DIV_RST    8'h00
// timing
`define ULSB_OSR16      6'h10
`define ULSB_OSR13      6'h0d
`define ULSB_RELOAD_WS  2'h2
`define ULSB_FIFO_DEPTH 5'h10
`endif

// File: src/ulsb_sync.v
// three-stage synchroniser; output follows once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module ulsb_sync
(
   // clock and reset
   input  wire ref_clk,
   input  wire rst_n,
   // pin in, clean level out
   input  wire pin_in,
   output reg  level_out
);
   reg s1_r;
   reg s2_r;
   reg s3_r;

   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_r      <= 1'b1;
         s2_r      <= 1'b1;
         s3_r      <= 1'b1;
         level_out <= 1'b1;
      end
      else
      begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r)
            level_out <= s3_r;
      end
   end
endmodule // ulsb_sync
`default_nettype wire

// File: src/ulsb_baud.v
// baud generator: one sample enable every divisor clocks, held while reloading
`timescale 1ns/100ps
`default_nettype none
module ulsb_baud
(
   // clock and reset
   input  wire        ref_clk,
   input  wire        rst_n,
   // control
   input  wire [15:0] divisor,
   input  wire        reload,
   // sample enable, oversample ratio is counted by the user
   output reg         samp_tick
);
   reg [15:0] cnt_r;

   // bit time is divisor times the oversample count; zero divisor stops it
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_r     <= 16'h0000;
         samp_tick <= 1'b0;
      end
      else if (reload || divisor == 16'h0000)
      begin
         cnt_r     <= 16'h0000;
         samp_tick <= 1'b0;
      end
      else if (cnt_r >= divisor - 16'h0001)
      begin
         cnt_r     <= 16'h0000;
         samp_tick <= 1'b1;
      end
      else
      begin
         cnt_r     <= cnt_r + 16'h0001;
         samp_tick <= 1'b0;
      end
   end
endmodule // ulsb_baud
`default_nettype wire

// File: src/ulsb_top.v
// serial port core with line status, divisor latches, run controls and oversample select
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "ulsb_regs.vh"
//////////////////////////////////////////////////////////////////////////////////////////////////
// Function
// - bit7 flags any stored faulty character
// - bit6 set when holding and shifter empty
// - bit5 set when holding stage drained
// - bit4 break: line low whole character
// - fifo error flags follow head character
// - bad stop sets bit3, wait line high
// - bit2 set on parity mismatch
// - line error flags request interrupt
// - bit1 overwrite overrun, cleared by read
// - fifo overrun drops new character
// - bit0 set while unread characters exist
// - divisor built from two byte latches
// - divisor write holds generator two cycles
// - select bit steers shared addresses
// - divisor latches also at dedicated addresses
// - bit14 runs or resets transmitter
// - bit13 runs or resets receiver
// - suspend halts after current word
// - mode bit0 picks 16x or 13x
// - select bit is format bit7, reset 0
module ulsb_top
(
   // clock and reset
   input  wire        ref_clk,
   input  wire        rst_n,
   // register port
   input  wire [5:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [31:0] reg_rdata,
   // serial line
   input  wire        rx_pin,
   output reg         tx_pin,
   // system
   input  wire        emu_suspend,
   output wire        irq
);
   localparam T_IDLE = 3'h0, T_START = 3'h1, T_DATA = 3'h2, T_PAR = 3'h3, T_STOP = 3'h4;
   localparam R_IDLE = 3'h0, R_START = 3'h1, R_DATA = 3'h2, R_PAR = 3'h3, R_STOP = 3'h4,
              R_WAITHI = 3'h5;
   //////////////////////////////////////////////////////////////////////////////////////////////
   reg  [7:0]  lcr_r;
   reg  [2:0]  ier_r;
   reg         fifo_en_r;
   reg  [7:0]  dll_r;
   reg  [7:0]  dlh_r;
   reg         tx_run_r;
   reg         rx_run_r;
   reg         free_r;
   reg         osm_r;
   reg         oe_r;
   reg  [1:0]  reload_r;
   reg  [7:0]  tx_mem [0:15];
   reg  [3:0]  tx_wp_r;
   reg  [3:0]  tx_rp_r;
   reg  [4:0]  tx_cnt_r;
   reg  [10:0] rx_mem [0:15];
   reg  [3:0]  rx_wp_r;
   reg  [3:0]  rx_rp_r;
   reg  [4:0]  rx_cnt_r;
   reg  [2:0]  ts_r;
   reg  [7:0]  tsh_r;
   reg  [5:0]  tsamp_r;
   reg  [2:0]  tbit_r;
   reg         tpar_r;
   reg  [2:0]  rs_r;
   reg  [7:0]  rsh_r;
   reg  [5:0]  rsamp_r;
   reg  [2:0]  rbit_r;
   reg         rperr_r;
   reg         rpbit_r;
   reg         rx_fifo_error;
   reg  [4:0]  k;
   reg  [3:0]  idx;
   wire        rx_lvl;
   wire        samp_tick;
   wire        halt;
   wire        divisor_select;
   wire [5:0]  osr;
   wire [5:0]  half;
   wire [2:0]  wlast;
   wire [4:0]  cap;
   wire        wr_thr;
   wire        rd_rbr;
   wire        wr_dll;
   wire        wr_dlh;
   wire        tx_pop;
   wire        rx_pop;
   wire        rx_done;
   wire [10:0] rx_word;
   wire [7:0]  rx_data;
   wire        tx_hold_empty;
   wire        tx_all_empty;
   wire        dr;
   wire [2:0]  head_err;
   wire [7:0]  line_status;
   wire [5:0]  stop_len;
   wire        stop_bit;
   wire        brk;
   //////////////////////////////////////////////////////////////////////////////////////////////
   ulsb_sync u_sync
   (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .pin_in    (rx_pin),
      .level_out (rx_lvl)
   );

   ulsb_baud u_baud
   (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .divisor   ({dlh_r, dll_r}),
      .reload    (reload_r != 2'h0),
      .samp_tick (samp_tick)
   );
   //////////////////////////////////////////////////////////////////////////////////////////////
   assign halt  = emu_suspend & ~free_r;
   assign divisor_select  = lcr_r[`ULSB_LCR_DIVISOR_SELECT];
   assign osr   = osm_r ? `ULSB_OSR13 : `ULSB_OSR16;
   assign half  = {1'b0, osr[5:1]};
   assign wlast = {1'b1, lcr_r[1:0]};
   assign cap   = fifo_en_r ? `ULSB_FIFO_DEPTH : 5'h01;
   // shared addresses follow the select bit; dedicated ones never do
   assign wr_thr = reg_wr && reg_addr == `ULSB_A_BUF && !divisor_select;
   assign rd_rbr = reg_rd && reg_addr == `ULSB_A_BUF && !divisor_select;
   assign wr_dll = reg_wr && ((reg_addr == `ULSB_A_BUF && divisor_select) || reg_addr == `ULSB_A_DLL);
   assign wr_dlh = reg_wr && ((reg_addr == `ULSB_A_IER && divisor_select) || reg_addr == `ULSB_A_DLH);
   assign rx_pop = rd_rbr && rx_cnt_r != 5'h00;
   assign tx_pop = ts_r == T_IDLE && tx_cnt_r != 5'h00 && !halt && tx_run_r;
   // line status
   assign tx_hold_empty     = tx_cnt_r == 5'h00;
   assign tx_all_empty     = tx_hold_empty && ts_r == T_IDLE;
   assign dr       = rx_cnt_r != 5'h00;
   assign head_err = dr ? rx_mem[rx_rp_r][10:8] : 3'h0;
   assign line_status      = {rx_fifo_error, tx_all_empty, tx_hold_empty, head_err, oe_r, dr};
   assign irq = !halt && ((ier_r[`ULSB_IE_RX] && dr) || (ier_r[`ULSB_IE_TX] && tx_hold_empty) ||
                (ier_r[`ULSB_IE_LS] && (oe_r || head_err != 3'h0)));

   always @*
   begin
      rx_fifo_error = 1'b0;
      idx  = 4'h0;
      for (k = 5'h00; k < 5'h10; k = k + 5'h01)
      begin
         idx = rx_rp_r + k[3:0];
         if (k < rx_cnt_r && rx_mem[idx][10:8] != 3'h0)
            rx_fifo_error = 1'b1;
      end
   end
   //////////////////////////////////////////////////////////////////////////////////////////////
   // registers and read port
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lcr_r     <= `ULSB_LCR_RST;
         ier_r     <= 3'h0;
         fifo_en_r <= 1'b0;
         dll_r     <= `ULSB_DIV_RST;
         dlh_r     <= `ULSB_DIV_RST;
         tx_run_r  <= 1'b0;
         rx_run_r  <= 1'b0;
         free_r    <= 1'b0;
         osm_r     <= 1'b0;
         reload_r  <= 2'h0;
         reg_rdata <= 32'h00000000;
      end
      else
      begin
         if (wr_dll)
            dll_r <= reg_wdata[7:0];
         if (wr_dlh)
            dlh_r <= reg_wdata[7:0];
         if (wr_dll || wr_dlh)
            reload_r <= `ULSB_RELOAD_WS;
         else if (reload_r != 2'h0)
            reload_r <= reload_r - 2'h1;
         if (reg_wr && reg_addr == `ULSB_A_IER && !divisor_select)
            ier_r <= reg_wdata[2:0];
         if (reg_wr && reg_addr == `ULSB_A_FCTL)
            fifo_en_r <= reg_wdata[`ULSB_FC_EN];
         if (reg_wr && reg_addr == `ULSB_A_LCR)
            lcr_r <= reg_wdata[7:0];
         if (reg_wr && reg_addr == `ULSB_A_PWR)
         begin
            tx_run_r <= reg_wdata[`ULSB_PW_TXRUN];
            rx_run_r <= reg_wdata[`ULSB_PW_RXRUN];
            free_r   <= reg_wdata[`ULSB_PW_FREE];
         end
         if (reg_wr && reg_addr == `ULSB_A_MDR)
            osm_r <= reg_wdata[0];
         reg_rdata <= 32'h00000000;
         if (reg_rd)
            case (reg_addr)
               `ULSB_A_BUF:  reg_rdata[7:0] <= divisor_select ? dll_r : rx_mem[rx_rp_r][7:0];
               `ULSB_A_IER:  reg_rdata[7:0] <= divisor_select ? dlh_r : {5'h00, ier_r};
               `ULSB_A_FCTL: reg_rdata[0] <= fifo_en_r;
               `ULSB_A_LCR:  reg_rdata[7:0] <= lcr_r;
               `ULSB_A_LSR:  reg_rdata[7:0] <= line_status;
               `ULSB_A_DLL:  reg_rdata[7:0] <= dll_r;
               `ULSB_A_DLH:  reg_rdata[7:0] <= dlh_r;
               `ULSB_A_PWR:  reg_rdata[14:0] <= {tx_run_r, rx_run_r, 12'h000, free_r};
               `ULSB_A_MDR:  reg_rdata[0] <= osm_r;
               default:      reg_rdata <= 32'h00000000;
            endcase
      end
   end
   //////////////////////////////////////////////////////////////////////////////////////////////
   // transmit holding stage; a full stage silently drops further writes
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_wp_r  <= 4'h0;
         tx_rp_r  <= 4'h0;
         tx_cnt_r <= 5'h00;
      end
      else if (!tx_run_r || (reg_wr && reg_addr == `ULSB_A_FCTL &&
               (reg_wdata[`ULSB_FC_TXCLR] || reg_wdata[`ULSB_FC_EN] != fifo_en_r)))
      begin
         tx_wp_r  <= 4'h0;
         tx_rp_r  <= 4'h0;
         tx_cnt_r <= 5'h00;
      end
      else
      begin
         if (wr_thr && tx_cnt_r < cap)
         begin
            tx_mem[tx_wp_r] <= reg_wdata[7:0];
            tx_wp_r         <= tx_wp_r + 4'h1;
         end
         if (tx_pop)
            tx_rp_r <= tx_rp_r + 4'h1;
         tx_cnt_r <= tx_cnt_r + {4'h0, wr_thr && tx_cnt_r < cap} - {4'h0, tx_pop};
      end
   end

   assign stop_len = !lcr_r[`ULSB_LCR_STB] ? osr :
                     (lcr_r[1:0] == 2'h0 ? osr + half : {osr[4:0], 1'b0});

   // transmit shifter; a word in progress completes even when suspended, but clearing the bit14 run control aborts it
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ts_r    <= T_IDLE;
         tsh_r   <= 8'h00;
         tsamp_r <= 6'h00;
         tbit_r  <= 3'h0;
         tpar_r  <= 1'b0;
         tx_pin  <= 1'b1;
      end
      else if (!tx_run_r)
      begin
         ts_r   <= T_IDLE;
         tx_pin <= 1'b1;
      end
      else
      begin
         case (ts_r)
            T_IDLE:
            begin
               tx_pin <= !lcr_r[`ULSB_LCR_BC];
               if (tx_pop)
               begin
                  tsh_r   <= tx_mem[tx_rp_r];
                  tpar_r  <= 1'b0;
                  tsamp_r <= 6'h00;
                  ts_r    <= T_START;
               end
            end
            T_START: tx_pin <= 1'b0;
            T_DATA:  tx_pin <= tsh_r[0];
            T_PAR:   tx_pin <= lcr_r[`ULSB_LCR_SP] ? !lcr_r[`ULSB_LCR_EPS] :
                               (tpar_r ^ !lcr_r[`ULSB_LCR_EPS]);
            T_STOP:  tx_pin <= 1'b1;
            default: ts_r <= T_IDLE;
         endcase
         if (lcr_r[`ULSB_LCR_BC] && ts_r != T_IDLE)
            tx_pin <= 1'b0;
         if (samp_tick && ts_r != T_IDLE)
         begin
            tsamp_r <= tsamp_r + 6'h01;
            if (ts_r == T_STOP ? tsamp_r == stop_len - 6'h01 : tsamp_r == osr - 6'h01)
            begin
               tsamp_r <= 6'h00;
               case (ts_r)
                  T_START:
                  begin
                     tbit_r <= 3'h0;
                     ts_r   <= T_DATA;
                  end
                  T_DATA:
                  begin
                     tpar_r <= tpar_r ^ tsh_r[0];
                     tsh_r  <= {1'b0, tsh_r[7:1]};
                     tbit_r <= tbit_r + 3'h1;
                     if (tbit_r == wlast)
                        ts_r <= lcr_r[`ULSB_LCR_PEN] ? T_PAR : T_STOP;
                  end
                  T_PAR:   ts_r <= T_STOP;
                  default: ts_r <= T_IDLE;
               endcase
            end
         end
      end
   end
   //////////////////////////////////////////////////////////////////////////////////////////////
   // receiver
   assign rx_data  = rsh_r >> (3'h7 - wlast);
   assign stop_bit = rx_lvl;
   assign brk      = rx_data == 8'h00 && !stop_bit && (!lcr_r[`ULSB_LCR_PEN] || !rpbit_r);
   assign rx_done  = samp_tick && rs_r == R_STOP && rsamp_r == osr - 6'h01;
   assign rx_word  = {brk, !stop_bit, rperr_r, rx_data};

   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rs_r    <= R_IDLE;
         rsh_r   <= 8'h00;
         rsamp_r <= 6'h00;
         rbit_r  <= 3'h0;
         rperr_r <= 1'b0;
         rpbit_r <= 1'b0;
      end
      else if (!rx_run_r)
         rs_r <= R_IDLE;
      else
         case (rs_r)
            R_IDLE:
               if (!rx_lvl && !halt)
               begin
                  rsamp_r <= 6'h00;
                  rs_r    <= R_START;
               end
            R_START:
               if (samp_tick)
               begin
                  rsamp_r <= rsamp_r + 6'h01;
                  if (rsamp_r == half - 6'h01)
                  begin
                     rsamp_r <= 6'h00;
                     rbit_r  <= 3'h0;
                     rperr_r <= 1'b0;
                     rs_r    <= rx_lvl ? R_IDLE : R_DATA;
                  end
               end
            R_DATA, R_PAR, R_STOP:
               if (samp_tick)
               begin
                  rsamp_r <= rsamp_r + 6'h01;
                  if (rsamp_r == osr - 6'h01)
                  begin
                     rsamp_r <= 6'h00;
                     if (rs_r == R_DATA)
                     begin
                        rsh_r  <= {rx_lvl, rsh_r[7:1]};
                        rbit_r <= rbit_r + 3'h1;
                        if (rbit_r == wlast)
                           rs_r <= lcr_r[`ULSB_LCR_PEN] ? R_PAR : R_STOP;
                     end
                     else if (rs_r == R_PAR)
                     begin
                        rpbit_r <= rx_lvl;
                        rperr_r <= rx_lvl != (lcr_r[`ULSB_LCR_SP] ? !lcr_r[`ULSB_LCR_EPS] :
                                   (^rx_data ^ !lcr_r[`ULSB_LCR_EPS]));
                        rs_r    <= R_STOP;
                     end
                     else
                        rs_r <= stop_bit ? R_IDLE : R_WAITHI;
                  end
               end
            R_WAITHI:
               if (rx_lvl)
                  rs_r <= R_IDLE;
            default: rs_r <= R_IDLE;
         endcase
   end
   //////////////////////////////////////////////////////////////////////////////////////////////
   // receive buffer: one entry without fifo mode, sixteen with it
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_wp_r  <= 4'h0;
         rx_rp_r  <= 4'h0;
         rx_cnt_r <= 5'h00;
         oe_r     <= 1'b0;
      end
      else
      begin
         // new overrun wins over the clearing status read
         if (reg_rd && reg_addr == `ULSB_A_LSR)
            oe_r <= 1'b0;
         if (!rx_run_r || (reg_wr && reg_addr == `ULSB_A_FCTL &&
             (reg_wdata[`ULSB_FC_RXCLR] || reg_wdata[`ULSB_FC_EN] != fifo_en_r)))
         begin
            rx_wp_r  <= 4'h0;
            rx_rp_r  <= 4'h0;
            rx_cnt_r <= 5'h00;
         end
         else
         begin
            if (rx_pop)
               rx_rp_r <= rx_rp_r + 4'h1;
            if (rx_done && rx_cnt_r - {4'h0, rx_pop} < cap)
            begin
               rx_mem[rx_wp_r] <= rx_word;
               rx_wp_r         <= rx_wp_r + 4'h1;
               rx_cnt_r        <= rx_cnt_r + 5'h01 - {4'h0, rx_pop};
            end
            else
            begin
               rx_cnt_r <= rx_cnt_r - {4'h0, rx_pop};
               if (rx_done && !halt)
               begin
                  oe_r <= 1'b1;
                  if (!fifo_en_r)
                     rx_mem[rx_rp_r] <= rx_word;
               end
            end
         end
      end
   end
endmodule // ulsb_top
`default_nettype wire

// File: sim/ulsb_monitor.sv
// port checker for the serial port status block
`timescale 1ns/100ps
`default_nettype none
`include "ulsb_regs.vh"
module ulsb_monitor
(
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        rst_n,
   // register port
   input wire logic [5:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   // serial line and system
   input wire logic        rx_pin,
   input wire logic        tx_pin,
   input wire logic        emu_suspend,
   input wire logic        irq
);
   // shadows of the divisor, enable, select, power and mode fields, rebuilt from bus writes
   logic [7:0] dll_r, dlh_r, ier_r;
   logic       divisor_select_r, mdr_r;
   logic [2:0] pwr_r;
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         {dll_r, dlh_r, ier_r, divisor_select_r, mdr_r, pwr_r} <= '0;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            `ULSB_A_BUF: if (divisor_select_r) dll_r <= reg_wdata[7:0];
            `ULSB_A_IER: if (divisor_select_r) dlh_r <= reg_wdata[7:0]; else ier_r <= reg_wdata[7:0];
            `ULSB_A_LCR: divisor_select_r <= reg_wdata[7];
            `ULSB_A_DLL: dll_r <= reg_wdata[7:0];
            `ULSB_A_DLH: dlh_r <= reg_wdata[7:0];
            `ULSB_A_PWR: pwr_r <= {reg_wdata[14], reg_wdata[13], reg_wdata[0]};
            `ULSB_A_MDR: mdr_r <= reg_wdata[0];
            default: ;
         endcase
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence rd_dll;
      reg_rd && (reg_addr == `ULSB_A_DLL || (reg_addr == `ULSB_A_BUF && divisor_select_r));
   endsequence
   sequence rd_dlh;
      reg_rd && (reg_addr == `ULSB_A_DLH || (reg_addr == `ULSB_A_IER && divisor_select_r));
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data not zero outside a read");
   dll_read_a: assert property (rd_dll |=> reg_rdata == {24'h0, $past(dll_r)})
      else $error("low divisor read wrong");
   dlh_read_a: assert property (rd_dlh |=> reg_rdata == {24'h0, $past(dlh_r)})
      else $error("high divisor read wrong");
   run_bits_a: assert property (reg_rd && reg_addr == `ULSB_A_PWR |=>
      reg_rdata == {17'h0, $past(pwr_r[2]), $past(pwr_r[1]), 12'h0, $past(pwr_r[0])})
      else $error("power control read wrong");
   mode_read_a: assert property (reg_rd && reg_addr == `ULSB_A_MDR |=> reg_rdata == {31'h0, $past(mdr_r)})
      else $error("mode read wrong");
   status_shape_a: assert property (reg_rd && reg_addr == `ULSB_A_LSR |=>
      reg_rdata[31:8] == 24'h0 && !(reg_rdata[6] && !reg_rdata[5]))
      else $error("line status shape wrong");
   select_bit_a: assert property (reg_rd && reg_addr == `ULSB_A_LCR |=> reg_rdata[7] == $past(divisor_select_r))
      else $error("divisor select read wrong");
   irq_quiet_a: assert property (ier_r == 8'h0 && $past(ier_r) == 8'h0 |-> !irq)
      else $error("interrupt with all enables off");
   suspend_irq_a: assert property ((emu_suspend && !pwr_r[0]) [*4] |-> !irq)
      else $error("interrupt while suspended");
   tx_held_a: assert property ((!pwr_r[2]) [*3] |-> tx_pin)
      else $error("transmit line active in reset");
endmodule // ulsb_monitor
`default_nettype wire

// File: sim/ulsb_far_end.sv
// remote serial port model on the receive and transmit lines
`timescale 1ns/100ps
`default_nettype none
module ulsb_far_end
(
   // clock for bit timing
   input wire logic ref_clk,
   // lines seen from the far side
   input wire logic tx_pin,
   output var logic rx_pin
);
   int         bt = 16;
   int         n_got = 0;
   logic [7:0] got;
   initial rx_pin = 1'b1;
   task automatic bit_out(input logic v);
      rx_pin <= v;
      repeat (bt) @(posedge ref_clk);
   endtask
   // one 8-bit character; a trailing idle bit returns the line high after a bad stop
   task automatic send(input logic [7:0] c, input logic pen, input logic pbad, input logic stop);
      @(posedge ref_clk);
      bit_out(1'b0);
      for (int i = 0; i < 8; i++) bit_out(c[i]);
      if (pen) bit_out(^c ^ pbad);
      bit_out(stop);
      bit_out(1'b1);
   endtask
   // low for longer than a whole character
   task automatic brk;
      @(posedge ref_clk);
      repeat (12) bit_out(1'b0);
      repeat (2) bit_out(1'b1);
   endtask
   // receiver samples each data bit near its middle
   initial forever
   begin
      @(negedge tx_pin);
      repeat (bt / 2) @(posedge ref_clk);
      for (int i = 0; i < 8; i++)
      begin
         repeat (bt) @(posedge ref_clk);
         got[i] = tx_pin;
      end
      n_got++;
   end
endmodule // ulsb_far_end
`default_nettype wire

// File: sim/tb_ulsb_top.sv
// self-checking bench for the serial port status block
`timescale 1ns/100ps
`default_nettype none
`include "ulsb_regs.vh"
module tb_ulsb_top;
   localparam logic [31:0] F = 32'hffffffff;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [5:0]  reg_addr = 6'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        emu_suspend = 1'b0;
   wire  [31:0] reg_rdata;
   wire         rx_pin, tx_pin, irq;
   int          n_errors = 0;
   int          checks_done = 0;
   logic [31:0] d;
   always #12.5 ref_clk = ~ref_clk;
   ulsb_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_pin(rx_pin), .tx_pin(tx_pin),
      .emu_suspend(emu_suspend), .irq(irq));
   ulsb_far_end far_u (.ref_clk(ref_clk), .tx_pin(tx_pin), .rx_pin(rx_pin));
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e)
      begin
         $display("Error %s expected %h seen %h", nm, e, g);
         n_errors++;
      end
   endtask
   task automatic rc(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
      rd(a);
      chk(nm, d & m, e);
   endtask
   initial
   begin
      repeat (100000) @(posedge ref_clk);
      n_errors++;
      tally_and_finish();
   end
   initial
   begin
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      rc(`ULSB_A_LSR, F, 32'h60, "status reset");
      rc(`ULSB_A_DLL, F, 32'h0, "divisor reset");
      rc(6'h3c, F, 32'h0, "unmapped");
      wr(`ULSB_A_LCR, 32'h83);
      wr(`ULSB_A_BUF, 32'ha5);
      wr(`ULSB_A_IER, 32'h5a);
      rc(`ULSB_A_DLL, F, 32'ha5, "low latch");
      rc(`ULSB_A_DLH, F, 32'h5a, "high latch");
      wr(`ULSB_A_LCR, 32'h03);
      rc(`ULSB_A_LCR, F, 32'h03, "format");
      rc(`ULSB_A_IER, F, 32'h0, "enables");
      wr(`ULSB_A_DLL, 32'h01);
      wr(`ULSB_A_DLH, 32'h00);
      // receiver still held: nothing arrives
      wr(`ULSB_A_PWR, 32'h4001);
      far_u.send(8'h3c, 1'b0, 1'b0, 1'b1);
      rc(`ULSB_A_LSR, F, 32'h60, "rx held");
      wr(`ULSB_A_PWR, 32'h6001);
      rc(`ULSB_A_PWR, F, 32'h6001, "run bits");
      wr(`ULSB_A_BUF, 32'h5a);
      rc(`ULSB_A_LSR, 32'h40, 32'h0, "tx busy");
      for (int i = 0; i < 400 && far_u.n_got != 1; i++) @(posedge ref_clk);
      chk("tx char", {24'h0, far_u.got}, 32'h5a);
      repeat (40) @(posedge ref_clk);
      rc(`ULSB_A_LSR, F, 32'h60, "tx drained");
      far_u.send(8'h3c, 1'b0, 1'b0, 1'b1);
      rc(`ULSB_A_LSR, F, 32'h61, "data ready");
      rc(`ULSB_A_BUF, F, 32'h3c, "rx char");
      far_u.send(8'h11, 1'b0, 1'b0, 1'b1);
      far_u.send(8'h22, 1'b0, 1'b0, 1'b1);
      rc(`ULSB_A_LSR, F, 32'h63, "overwrite");
      rc(`ULSB_A_BUF, F, 32'h22, "newest kept");
      rc(`ULSB_A_LSR, F, 32'h60, "overrun cleared");
      wr(`ULSB_A_LCR, 32'h1b);
      far_u.send(8'h07, 1'b1, 1'b1, 1'b1);
      rc(`ULSB_A_LSR, F, 32'he5, "parity");
      rd(`ULSB_A_BUF);
      far_u.send(8'h07, 1'b1, 1'b0, 1'b0);
      rc(`ULSB_A_LSR, F, 32'he9, "framing");
      rd(`ULSB_A_BUF);
      far_u.brk();
      rc(`ULSB_A_LSR, 32'h91, 32'h91, "break");
      rd(`ULSB_A_BUF);
      rc(`ULSB_A_LSR, 32'h9f, 32'h0, "error gone");
      wr(`ULSB_A_IER, 32'h01);
      far_u.send(8'h33, 1'b1, 1'b0, 1'b1);
      chk("rx irq", {31'h0, irq}, 32'h1);
      rd(`ULSB_A_BUF);
      chk("rx irq off", {31'h0, irq}, 32'h0);
      wr(`ULSB_A_IER, 32'h04);
      far_u.send(8'h33, 1'b1, 1'b1, 1'b1);
      chk("status irq", {31'h0, irq}, 32'h1);
      wr(`ULSB_A_PWR, 32'h6000);
      emu_suspend <= 1'b1;
      repeat (8) @(posedge ref_clk);
      chk("suspend irq", {31'h0, irq}, 32'h0);
      rc(`ULSB_A_LCR, F, 32'h1b, "suspend access");
      emu_suspend <= 1'b0;
      wr(`ULSB_A_PWR, 32'h6001);
      rd(`ULSB_A_BUF);
      wr(`ULSB_A_IER, 32'h00);
      wr(`ULSB_A_MDR, 32'h01);
      rc(`ULSB_A_MDR, F, 32'h01, "mode");
      far_u.bt = 13;
      far_u.send(8'hc3, 1'b1, 1'b0, 1'b1);
      rc(`ULSB_A_BUF, F, 32'hc3, "13x char");
      wr(`ULSB_A_MDR, 32'h00);
      far_u.bt = 16;
      wr(`ULSB_A_FCTL, 32'h01);
      for (int i = 0; i < 17; i++) far_u.send(8'h40 + i[7:0], 1'b1, i == 0, 1'b1);
      rc(`ULSB_A_LSR, F, 32'he7, "fifo overrun");
      rc(`ULSB_A_BUF, F, 32'h40, "fifo head");
      rc(`ULSB_A_LSR, F, 32'h61, "next head");
      for (int i = 0; i < 15; i++) rd(`ULSB_A_BUF);
      chk("last stored", d, 32'h4f);
      rc(`ULSB_A_LSR, F, 32'h60, "fifo empty");
      wr(`ULSB_A_IER, 32'h02);
      rc(`ULSB_A_IER, F, 32'h02, "tx enable");
      chk("tx irq", {31'h0, irq}, 32'h1);
      tally_and_finish();
   end
endmodule // tb_ulsb_top
bind ulsb_top ulsb_monitor mon_u (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_pin(rx_pin),
   .tx_pin(tx_pin), .emu_suspend(emu_suspend), .irq(irq));
`default_nettype wire
